/* File: cpu_ahb_clock_reset_bridge.sv */
// core-to-bus master bridge with clock divider, reset merge and debug conditioning
`timescale 1ns/1ps
// Behaviour
// RULE1: core native bus becomes bus master port
// RULE2: core and bus clocks from one divider
// RULE3: hardware reset synchronised, watchdog request accepted
// RULE4: bus reset releases on bus clock rise
// RULE5: reset and debug inputs synchronised first; watchdog_timeout_in drives the bus reset merge without a synchroniser
// RULE6: watchdog timeout active high, unconnected reads low
// RULE7: separate active-low watchdog reset output
// RULE8: watchdog reset only on hardware reset
// RULE9: bus request driven, grant accepted
// RULE10: full-width address, type, size, burst, protection, response
// RULE11: core clock enable stalls core
// RULE12: bus reset on either source, one cycle minimum
module cpu_ahb_clock_reset_bridge (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hardware_reset_n,
  input wire logic watchdog_timeout_in = 1'b0,
  output logic watchdog_reset_out_n,
  output logic core_clock,
  output logic bus_clock,
  output logic bus_reset_n,
  input wire logic [31:0] core_addr,
  input wire logic [1:0] core_trans,
  input wire logic core_write,
  input wire logic [1:0] core_size,
  input wire logic [1:0] core_prot,
  input wire logic core_lock,
  input wire logic [31:0] core_wdata,
  output logic [31:0] core_rdata,
  output logic core_abort,
  output logic core_clock_enable,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [2:0] hburst,
  output logic [3:0] hprot,
  output logic hlock,
  output logic [31:0] hwdata,
  output logic hbusreq,
  input wire logic hgrant,
  input wire logic hready,
  input wire logic [1:0] hresp,
  input wire logic [31:0] hrdata,
  input wire logic dbg_trst_n_in,
  input wire logic dbg_tms_in,
  input wire logic dbg_tdi_in,
  input wire logic dbg_tck_in,
  output logic [bridge_pkg::JTAG_W-1:0] core_dbg_jtag,
  input wire logic core_dbg_tdo,
  input wire logic core_dbg_tdo_en_n,
  output logic dbg_tdo_out,
  output logic dbg_tdo_en_n_out
);
  logic hw_rst_sync_n;
  logic next_bus_reset_n;
  logic bus_rise;
  logic core_active;
  logic addr_take;
  logic sources_clear;

  // hardware reset through the synchroniser before use (see RULE3) (see RULE5)
  sync_stages #(.WIDTH(1), .RESET_VALUE(1'b0)) u_rst_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in(hardware_reset_n),
    .sync_out(hw_rst_sync_n)
  );

  // debug probe trst, tms, tdi, tck synchronised to the bus domain (see RULE5)
  sync_stages #(.WIDTH(bridge_pkg::JTAG_W), .RESET_VALUE(bridge_pkg::JTAG_IDLE)) u_jtag_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in({dbg_trst_n_in, dbg_tms_in, dbg_tdi_in, dbg_tck_in}),
    .sync_out(core_dbg_jtag)
  );

  // decode: bus clock rises on the next edge when it is low now
  assign bus_rise = !bus_clock;
  assign core_active = core_trans[1] && (core_trans != bridge_pkg::CORE_TRANS_COPROC);
  assign addr_take = bus_rise && hready && hgrant && bus_reset_n;
  // either source asserts the bus reset; watchdog input high means timeout
  assign next_bus_reset_n = hw_rst_sync_n && !watchdog_timeout_in; // see RULE12 see RULE6

  // both clocks toggle from one divider so they share every edge (see RULE2)
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      core_clock <= 1'b0;
      bus_clock <= 1'b0;
    end else begin
      core_clock <= !core_clock;
      bus_clock <= !bus_clock;
    end
  end

  // sources must read clear on two edges in a row, so a one-clock pulse
  // still holds the bus reset for a whole bus period (see RULE12)
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sources_clear <= 1'b0;
    end else begin
      sources_clear <= next_bus_reset_n;
    end
  end

  // assert at once, release only with a bus clock rise (see RULE4) (see RULE12)
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bus_reset_n <= 1'b0;
    end else if (!next_bus_reset_n) begin
      bus_reset_n <= 1'b0;
    end else if (bus_rise && sources_clear) begin
      bus_reset_n <= 1'b1;
    end
  end

  // watchdog reset follows hardware reset only (see RULE7) (see RULE8)
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      watchdog_reset_out_n <= 1'b0;
    end else begin
      watchdog_reset_out_n <= hw_rst_sync_n;
    end
  end

  // address phase taken from the core on every ready bus rise; transfer type stays idle unless granted (see RULE1) (see RULE10)
  always_ff @(posedge clk) begin
    if (!rst_n || !bus_reset_n) begin
      haddr <= bridge_pkg::ADDR_RESET;
      htrans <= bridge_pkg::TRANS_IDLE;
      hwrite <= 1'b0;
      hsize <= '0;
      hburst <= bridge_pkg::BURST_SINGLE;
      hprot <= '0;
      hlock <= 1'b0;
    end else if (bus_rise && hready) begin
      haddr <= core_addr;
      htrans <= addr_take && core_active ? core_trans : bridge_pkg::TRANS_IDLE;
      hwrite <= core_write;
      hsize <= {bridge_pkg::SIZE_UPPER, core_size};
      hburst <= core_trans == bridge_pkg::TRANS_SEQ ? bridge_pkg::BURST_INCR
                                                     : bridge_pkg::BURST_SINGLE;
      hprot <= {bridge_pkg::PROT_UPPER, core_prot};
      hlock <= core_lock;
    end
  end

  // request while the core wants the bus (see RULE9)
  always_ff @(posedge clk) begin
    if (!rst_n || !bus_reset_n) begin
      hbusreq <= 1'b0;
    end else if (bus_rise) begin
      hbusreq <= core_active;
    end
  end

  // data phase: write data out, read data and error back to the core
  always_ff @(posedge clk) begin
    if (!rst_n || !bus_reset_n) begin
      hwdata <= bridge_pkg::DATA_RESET;
      core_rdata <= bridge_pkg::DATA_RESET;
      core_abort <= 1'b0;
    end else if (bus_rise) begin
      if (hready) begin
        hwdata <= core_wdata;
        core_rdata <= hrdata;
      end
      core_abort <= hready && (hresp == bridge_pkg::RESP_ERROR); // see RULE10
    end
  end

  // stall the core while the bus extends a transfer or is not granted (see RULE11)
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      core_clock_enable <= 1'b0;
    end else if (bus_rise) begin
      core_clock_enable <= bus_reset_n && hready && (hgrant || !core_active);
    end
  end

  // debug return path registered toward the probe
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dbg_tdo_out <= 1'b0;
      dbg_tdo_en_n_out <= 1'b1;
    end else begin
      dbg_tdo_out <= core_dbg_tdo;
      dbg_tdo_en_n_out <= core_dbg_tdo_en_n;
    end
  end

  // checks on clock, reset and bus behaviour
  AST_CLK_MATCH: assert property (@(posedge clk) disable iff (!rst_n) // see RULE2
    core_clock == bus_clock) else $error("core and bus clock differ");
  AST_CLK_TOGGLE: assert property (@(posedge clk) disable iff (!rst_n) // see RULE2
    rst_n |=> bus_clock != $past(bus_clock)) else $error("bus clock did not toggle");
  AST_RST_RELEASE: assert property (@(posedge clk) disable iff (!rst_n) // see RULE4
    $rose(bus_reset_n) |-> $rose(bus_clock)) else $error("bus reset released off a rise");
  AST_HW_RST: assert property (@(posedge clk) disable iff (!rst_n) // see RULE3
    !hw_rst_sync_n |=> !bus_reset_n) else $error("hardware reset not applied");
  AST_HW_SYNC: assert property (@(posedge clk) disable iff (!rst_n) // see RULE5
    !hardware_reset_n ##1 !hardware_reset_n |=> !hw_rst_sync_n)
    else $error("reset sync latency wrong");
  AST_JTAG_SYNC: assert property (@(posedge clk) disable iff (!rst_n) // see RULE5
    dbg_tms_in ##1 dbg_tms_in |=> core_dbg_jtag[2]) else $error("tms sync latency wrong");
  AST_WDOG_RST: assert property (@(posedge clk) disable iff (!rst_n) // see RULE12
    watchdog_timeout_in |=> !bus_reset_n[*2]) else $error("watchdog reset too short");
  AST_WDOG_OUT: assert property (@(posedge clk) disable iff (!rst_n) // see RULE8
    watchdog_timeout_in && hw_rst_sync_n |=> watchdog_reset_out_n)
    else $error("watchdog reset itself");
  AST_WDOG_HW: assert property (@(posedge clk) disable iff (!rst_n) // see RULE7
    !hw_rst_sync_n |=> !watchdog_reset_out_n) else $error("watchdog reset missed");
  AST_STALL: assert property (@(posedge clk) disable iff (!rst_n) // see RULE11
    bus_rise && !hready |=> !core_clock_enable ##1 !core_clock_enable)
    else $error("core not stalled");
  AST_BUSREQ: assert property (@(posedge clk) disable iff (!rst_n || !bus_reset_n) // see RULE9
    bus_rise && core_active |=> hbusreq) else $error("no bus request");
  AST_ADDR: assert property (@(posedge clk) disable iff (!rst_n) // see RULE1
    addr_take && next_bus_reset_n && core_active |=> haddr == $past(core_addr) && htrans[1])
    else $error("address phase not passed");
  AST_ABORT: assert property (@(posedge clk) disable iff (!rst_n) // see RULE10
    $rose(core_abort) |-> $past(hresp) == bridge_pkg::RESP_ERROR) else $error("spurious abort");

  COV_WDOG: cover property (@(posedge clk) disable iff (!rst_n)
    watchdog_timeout_in ##1 !bus_reset_n && watchdog_reset_out_n);
  COV_RELEASE: cover property (@(posedge clk) disable iff (!rst_n) $rose(bus_reset_n));
  COV_XFER: cover property (@(posedge clk) disable iff (!rst_n)
    addr_take && core_active ##2 hready);
  COV_ERROR: cover property (@(posedge clk) disable iff (!rst_n) $rose(core_abort));
endmodule

/* File: bridge_pkg.sv */
// shared constants for the core-to-bus bridge with clock and reset conditioning
package bridge_pkg;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int SYNC_STAGES = 2;
  localparam int JTAG_W = 4;
  // bus transfer types
  localparam logic [1:0] TRANS_IDLE = 2'h0;
  localparam logic [1:0] TRANS_NONSEQ = 2'h2;
  localparam logic [1:0] TRANS_SEQ = 2'h3;
  // core native transfer type for a coprocessor cycle, never put on the bus
  localparam logic [1:0] CORE_TRANS_COPROC = 2'h1;
  // burst encodings
  localparam logic [2:0] BURST_SINGLE = 3'h0;
  localparam logic [2:0] BURST_INCR = 3'h1;
  // responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_ERROR = 2'h1;
  // upper protection bits: not bufferable, not cacheable
  localparam logic [1:0] PROT_UPPER = 2'h0;
  localparam logic SIZE_UPPER = 1'b0;
  // reset values
  localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
  localparam logic [31:0] DATA_RESET = 32'h0000_0000;
  localparam logic [3:0] JTAG_IDLE = 4'h0;
endpackage

/* File: sync_stages.sv */
// two-flop synchroniser, one per bit
`timescale 1ns/1ps
module sync_stages #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta;

  // first stage is read only by the second
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta <= RESET_VALUE;
      sync_out <= RESET_VALUE;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule

/* File: ahb_slave_model.sv */
// bus slave model answering the master port of the bridge
`timescale 1ns/1ps
module ahb_slave_model (
  input wire logic clk,
  input wire logic bus_clock,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic stall,
  input wire logic err,
  output logic hready,
  output logic [1:0] hresp,
  output logic [31:0] hrdata
);
  initial begin
    hready = 1'b1;
    hresp = bridge_pkg::RESP_OKAY;
    hrdata = 32'h0000_0000;
  end
  // answers change just after each bus rise; read data is the inverted address
  always @(posedge clk) begin
    if (bus_clock === 1'b0) begin
      hready <= ~stall;
      // error response while the bench asks for one
      hresp <= err ? bridge_pkg::RESP_ERROR : bridge_pkg::RESP_OKAY;
      if (hready && htrans[1]) begin
        hrdata <= ~haddr;
      end else begin
        hrdata <= ~hrdata; // idle data bus keeps changing
      end
    end
  end
endmodule

/* File: tb.sv */
// testbench for the bridge with a bus slave model
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hw_n = 1'b1;
  logic wdog = 1'b0;
  logic grant = 1'b1;
  logic stall = 1'b0;
  logic err = 1'b0;
  logic wr = 1'b0;
  logic [31:0] addr = 32'h0000_0000;
  logic [1:0] trans = 2'h0;
  logic [3:0] dbg = 4'h0;
  logic wdr_n, core_clock, bus_clock, bus_reset_n, hready, cke, hbusreq;
  logic abort, hwrite, hlock, tdo, tdo_en_n;
  logic [31:0] haddr, hrdata, rdata, hwdata;
  logic [1:0] htrans, hresp;
  logic [2:0] hsize, hburst;
  logic [3:0] hprot, jtag;
  int n_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  cpu_ahb_clock_reset_bridge uut (.clk(clk), .rst_n(rst_n), .hardware_reset_n(hw_n),
    .watchdog_timeout_in(wdog), .watchdog_reset_out_n(wdr_n), .core_clock(core_clock),
    .bus_clock(bus_clock), .bus_reset_n(bus_reset_n), .core_addr(addr), .core_trans(trans),
    .core_write(wr), .core_size(2'h2), .core_prot(2'h3), .core_lock(wr),
    .core_wdata(~addr), .core_rdata(rdata), .core_abort(abort), .core_clock_enable(cke),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hburst(hburst),
    .hprot(hprot), .hlock(hlock), .hwdata(hwdata), .hbusreq(hbusreq), .hgrant(grant),
    .hready(hready), .hresp(hresp),
    .hrdata(hrdata), .dbg_trst_n_in(dbg[3]), .dbg_tms_in(dbg[2]), .dbg_tdi_in(dbg[1]),
    .dbg_tck_in(dbg[0]), .core_dbg_jtag(jtag), .core_dbg_tdo(dbg[1]),
    .core_dbg_tdo_en_n(dbg[0]), .dbg_tdo_out(tdo), .dbg_tdo_en_n_out(tdo_en_n));
  ahb_slave_model partner (.clk(clk), .bus_clock(bus_clock), .haddr(haddr), .htrans(htrans),
    .stall(stall), .err(err), .hready(hready), .hresp(hresp), .hrdata(hrdata));
  always #5 clk = ~clk;
  // cut a hang short
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_errors++;
      end_of_test;
    end
  end
  task automatic end_of_test;
    if (n_errors == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic chk1(input string w, input logic e, input logic g);
    chk(w, {31'h0, e}, {31'h0, g});
  endtask
  // returns at the edge just before a bus rise
  task automatic pre_rise;
    do @(posedge clk); while (bus_clock !== 1'b1);
  endtask
  task automatic wait_release;
    for (int i = 0; i < 12 && bus_reset_n !== 1'b1; i++) @(negedge clk);
    chk1("bus_clock at release", 1'b1, bus_clock);
    chk1("watchdog_reset_out_n", 1'b1, wdr_n);
  endtask
  task automatic t_resets;
    @(posedge clk) hw_n <= 1'b0;
    repeat (4) @(negedge clk);
    chk1("bus_reset_n on hw reset", 1'b0, bus_reset_n);
    chk1("watchdog_reset_out_n on hw reset", 1'b0, wdr_n);
    @(posedge clk) hw_n <= 1'b1;
    wait_release;
    @(posedge clk) wdog <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    chk1("bus_reset_n on timeout", 1'b0, bus_reset_n);
    chk1("watchdog_reset_out_n on timeout", 1'b1, wdr_n);
    @(posedge clk) wdog <= 1'b0;
    wait_release;
  endtask
  task automatic t_clocks;
    logic prev;
    prev = bus_clock;
    repeat (6) begin
      @(negedge clk);
      chk1("bus_clock toggle", ~prev, bus_clock);
      chk1("core_clock", bus_clock, core_clock);
      prev = bus_clock;
    end
  endtask
  task automatic t_xfer(input logic [31:0] a, input logic [1:0] tr, input logic [2:0] burst,
      input logic w);
    pre_rise;
    addr <= a;
    trans <= tr;
    wr <= w;
    @(posedge clk) trans <= bridge_pkg::TRANS_IDLE;
    @(negedge clk);
    chk("haddr", a, haddr);
    chk1("hwrite", w, hwrite);
    chk1("hlock", w, hlock);
    chk("htrans", {30'h0, tr}, {30'h0, htrans});
    chk("hsize", 32'h0000_0002, {29'h0, hsize});
    chk("hburst", {29'h0, burst}, {29'h0, hburst});
    chk("hprot", 32'h0000_0003, {28'h0, hprot});
    chk1("hbusreq", 1'b1, hbusreq);
    pre_rise;
    @(posedge clk);
    @(negedge clk);
    chk("hwdata", ~a, hwdata);
    pre_rise;
    @(posedge clk);
    @(negedge clk);
    chk("core_rdata", ~a, rdata);
  endtask
  // one error response from the slave reaches the core as an abort, then clears
  task automatic t_error;
    pre_rise;
    err <= 1'b1;
    @(posedge clk) err <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk1("core_abort on error", 1'b1, abort);
    repeat (2) @(negedge clk);
    chk1("core_abort after okay", 1'b0, abort);
  endtask
  task automatic t_stall_grant;
    pre_rise;
    stall <= 1'b1;
    repeat (5) @(negedge clk);
    chk1("core_clock_enable stalled", 1'b0, cke);
    @(posedge clk) stall <= 1'b0;
    repeat (7) @(negedge clk);
    chk1("core_clock_enable resumed", 1'b1, cke);
    pre_rise;
    grant <= 1'b0;
    trans <= bridge_pkg::TRANS_NONSEQ;
    repeat (2) @(negedge clk);
    chk("htrans without grant", 32'h0000_0000, {30'h0, htrans});
    chk1("hbusreq without grant", 1'b1, hbusreq);
    chk1("core_clock_enable without grant", 1'b0, cke);
    @(posedge clk) grant <= 1'b1;
    trans <= bridge_pkg::TRANS_IDLE;
  endtask
  task automatic t_debug(input logic [3:0] v);
    @(posedge clk) dbg <= v;
    repeat (4) @(negedge clk);
    chk("core_dbg_jtag", {28'h0, v}, {28'h0, jtag});
    chk1("dbg_tdo_out", v[1], tdo);
    chk1("dbg_tdo_en_n_out", v[0], tdo_en_n);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    wait_release;
    t_clocks;
    t_xfer(32'h8765_4320, bridge_pkg::TRANS_NONSEQ, bridge_pkg::BURST_SINGLE, 1'b1);
    t_xfer(32'h1234_5678, bridge_pkg::TRANS_SEQ, bridge_pkg::BURST_INCR, 1'b0);
    t_stall_grant;
    t_error;
    t_debug(4'ha);
    t_debug(4'h5);
    t_resets;
    end_of_test;
  end
endmodule
